// >>> core/tpc_pin_ctrl.sv
// Pin I/O control of a 16-bit timer: compare-match pin actions and input capture
//
// Summary of operation
// - With a channel in compare mode, its two-bit action field picks none, low, high or toggle.
// - With a channel in capture mode, the field picks rising (00), falling (01) or both (1X) edges.
// - Bit 6 of pin_ctrl_cd makes general_reg_d compare (0) or capture (1), reset 0.
// - Bit 7 of pin_ctrl_cd always reads 1 whatever software writes.
// - pin_ctrl_cd governs channels C and D exactly as pin_ctrl_ab governs A and B.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
module tpc_pin_ctrl
  import tpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] counter,
  input wire logic [3:0] timer_pin_in,
  output logic [3:0] timer_pin_out,
  output logic [3:0] timer_pin_oe_n,
  output logic [3:0] capture_evt,
  output logic [3:0] compare_evt
);

  logic [7:0] pin_ctrl_ab_ff, nxt_pin_ctrl_ab;
  logic [7:0] pin_ctrl_cd_ff, nxt_pin_ctrl_cd;
  logic [15:0] gen_reg_ff [NUM_CHAN];
  logic [15:0] nxt_gen_reg [NUM_CHAN];
  logic [3:0] pin_out_ff, nxt_pin_out;
  logic [3:0] sync1_ff, sync2_ff, sync3_ff;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [3:0] cap_ff, nxt_cap;
  logic [3:0] cmp_ff, nxt_cmp;
  logic [3:0] mode_cap;
  logic [1:0] act [NUM_CHAN];
  logic [3:0] match;
  logic [3:0] cap_hit;
  logic [3:0] rise;
  logic [3:0] fall;

  // Picks a channel's 4-bit nibble fields from the two control registers
  function automatic logic [3:0] chan_field(input logic [7:0] ab, input logic [7:0] cd,
                                            input int ch);
    logic [7:0] r;
    r = (ch < 2) ? ab : cd;
    chan_field = (ch % 2 == 0) ? r[3:0] : r[7:4];
  endfunction : chan_field

  // Edge selection: 1X takes both edges
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = sel[1] ? (r | f) : (sel == EDGE_FALL ? f : r);
  endfunction : edge_hit

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      logic [3:0] fld;
      fld = chan_field(pin_ctrl_ab_ff, pin_ctrl_cd_ff, i);
      mode_cap[i] = fld[MODE_LO_POS];
      act[i] = fld[1:0];
      rise[i] = sync2_ff[i] & ~sync3_ff[i];
      fall[i] = ~sync2_ff[i] & sync3_ff[i];
      match[i] = ~mode_cap[i] && (counter == gen_reg_ff[i]);
      cap_hit[i] = mode_cap[i] && edge_hit(act[i], rise[i], fall[i]);
    end
  end

  // Register writes, captures and pin actions
  always_comb begin
    nxt_pin_ctrl_ab = pin_ctrl_ab_ff;
    nxt_pin_ctrl_cd = pin_ctrl_cd_ff | PIN_CTRL_CD_RSVD;
    nxt_pin_out = pin_out_ff;
    nxt_cap = cap_hit;
    nxt_cmp = match;
    for (int i = 0; i < NUM_CHAN; i++) nxt_gen_reg[i] = gen_reg_ff[i];
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PIN_CTRL_AB: nxt_pin_ctrl_ab = reg_wdata[7:0];
        ADDR_PIN_CTRL_CD: nxt_pin_ctrl_cd = reg_wdata[7:0] | PIN_CTRL_CD_RSVD;
        ADDR_GENERAL_REG_A: nxt_gen_reg[0] = reg_wdata;
        ADDR_GENERAL_REG_B: nxt_gen_reg[1] = reg_wdata;
        ADDR_GENERAL_REG_C: nxt_gen_reg[2] = reg_wdata;
        ADDR_GENERAL_REG_D: nxt_gen_reg[3] = reg_wdata;
        default: ;
      endcase
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      // Capture beats a same-cycle software write so no edge is lost
      if (cap_hit[i]) nxt_gen_reg[i] = counter;
      if (match[i]) begin
        unique case (act[i])
          ACT_NONE: nxt_pin_out[i] = pin_out_ff[i];
          ACT_LOW: nxt_pin_out[i] = 1'b0;
          ACT_HIGH: nxt_pin_out[i] = 1'b1;
          ACT_TOGGLE: nxt_pin_out[i] = ~pin_out_ff[i];
        endcase
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PIN_CTRL_AB: nxt_rdata = {8'h00, pin_ctrl_ab_ff};
        ADDR_PIN_CTRL_CD: nxt_rdata = {8'h00, pin_ctrl_cd_ff | PIN_CTRL_CD_RSVD};
        ADDR_GENERAL_REG_A: nxt_rdata = gen_reg_ff[0];
        ADDR_GENERAL_REG_B: nxt_rdata = gen_reg_ff[1];
        ADDR_GENERAL_REG_C: nxt_rdata = gen_reg_ff[2];
        ADDR_GENERAL_REG_D: nxt_rdata = gen_reg_ff[3];
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_ctrl_ab_ff <= PIN_CTRL_AB_RST;
      pin_ctrl_cd_ff <= PIN_CTRL_CD_RST;
      pin_out_ff <= 4'h0;
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
      rdata_ff <= 16'h0000;
      cap_ff <= 4'h0;
      cmp_ff <= 4'h0;
      for (int i = 0; i < NUM_CHAN; i++) gen_reg_ff[i] <= GENERAL_REG_RST;
    end else begin
      pin_ctrl_ab_ff <= nxt_pin_ctrl_ab;
      pin_ctrl_cd_ff <= nxt_pin_ctrl_cd;
      pin_out_ff <= nxt_pin_out;
      sync1_ff <= timer_pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      rdata_ff <= nxt_rdata;
      cap_ff <= nxt_cap;
      cmp_ff <= nxt_cmp;
      for (int i = 0; i < NUM_CHAN; i++) gen_reg_ff[i] <= nxt_gen_reg[i];
    end
  end

  // Compare result is combinational so the pin value reaches the pad with the match cycle
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      timer_pin_out[i] = match[i] ? nxt_pin_out[i] : pin_out_ff[i];
      timer_pin_oe_n[i] = mode_cap[i];
    end
  end

  assign reg_rdata = rdata_ff;
  assign capture_evt = cap_ff;
  assign compare_evt = cmp_ff;

  // Register port: reserved bit, read-back of every register but pin_ctrl_cd, whose read is checked for bit 7 and a zero upper byte
  AST_CD_RSVD_ONE: assert property (@(posedge core_clk) disable iff (!nrst)
    pin_ctrl_cd_ff[RSVD_POS] == 1'b1)
    else $error("reserved bit not one");
  AST_RD_CD: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_PIN_CTRL_CD |=> reg_rdata[7] && reg_rdata[15:8] == 8'h00)
    else $error("pin_ctrl_cd read wrong");
  AST_RD_AB: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_PIN_CTRL_AB |=> reg_rdata == {8'h00, $past(pin_ctrl_ab_ff)})
    else $error("pin_ctrl_ab read wrong");
  AST_RD_GEN_A: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_GENERAL_REG_A |=> reg_rdata == $past(gen_reg_ff[0]))
    else $error("general_reg_a read wrong");
  AST_RD_GEN_B: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_GENERAL_REG_B |=> reg_rdata == $past(gen_reg_ff[1]))
    else $error("general_reg_b read wrong");
  AST_RD_GEN_C: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_GENERAL_REG_C |=> reg_rdata == $past(gen_reg_ff[2]))
    else $error("general_reg_c read wrong");
  AST_RD_GEN_D: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_GENERAL_REG_D |=> reg_rdata == $past(gen_reg_ff[3]))
    else $error("general_reg_d read wrong");

  // Compare pin actions, every action on every channel
  AST_LOW_ACT: assert property (@(posedge core_clk) disable iff (!nrst)
    match[0] && act[0] == ACT_LOW |-> timer_pin_out[0] == 1'b0 ##1 pin_out_ff[0] == 1'b0)
    else $error("drive low failed");
  AST_LOW_B: assert property (@(posedge core_clk) disable iff (!nrst)
    match[1] && act[1] == ACT_LOW |=> !pin_out_ff[1])
    else $error("drive low failed on b");
  AST_LOW_C: assert property (@(posedge core_clk) disable iff (!nrst)
    match[2] && act[2] == ACT_LOW |=> !pin_out_ff[2])
    else $error("drive low failed on c");
  AST_LOW_D: assert property (@(posedge core_clk) disable iff (!nrst)
    match[3] && act[3] == ACT_LOW |=> !pin_out_ff[3])
    else $error("drive low failed on d");
  AST_HIGH_A: assert property (@(posedge core_clk) disable iff (!nrst)
    match[0] && act[0] == ACT_HIGH |=> pin_out_ff[0])
    else $error("drive high failed on a");
  AST_HIGH_B: assert property (@(posedge core_clk) disable iff (!nrst)
    match[1] && act[1] == ACT_HIGH |=> pin_out_ff[1])
    else $error("drive high failed on b");
  AST_HIGH_ACT: assert property (@(posedge core_clk) disable iff (!nrst)
    match[2] && act[2] == ACT_HIGH |=> pin_out_ff[2])
    else $error("drive high failed");
  AST_HIGH_D: assert property (@(posedge core_clk) disable iff (!nrst)
    match[3] && act[3] == ACT_HIGH |=> pin_out_ff[3])
    else $error("drive high failed on d");
  AST_TOGGLE_A: assert property (@(posedge core_clk) disable iff (!nrst)
    match[0] && act[0] == ACT_TOGGLE |=> pin_out_ff[0] != $past(pin_out_ff[0]))
    else $error("toggle failed on a");
  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!nrst)
    match[1] && act[1] == ACT_TOGGLE |=> pin_out_ff[1] != $past(pin_out_ff[1]))
    else $error("toggle failed");
  AST_TOGGLE_C: assert property (@(posedge core_clk) disable iff (!nrst)
    match[2] && act[2] == ACT_TOGGLE |=> pin_out_ff[2] != $past(pin_out_ff[2]))
    else $error("toggle failed on c");
  AST_TOGGLE_D: assert property (@(posedge core_clk) disable iff (!nrst)
    match[3] && act[3] == ACT_TOGGLE |=> pin_out_ff[3] != $past(pin_out_ff[3]))
    else $error("toggle failed on d");
  AST_NONE_A: assert property (@(posedge core_clk) disable iff (!nrst)
    match[0] && act[0] == ACT_NONE |=> $stable(pin_out_ff[0]))
    else $error("none changed on a");
  AST_NONE_B: assert property (@(posedge core_clk) disable iff (!nrst)
    match[1] && act[1] == ACT_NONE |=> $stable(pin_out_ff[1]))
    else $error("none changed on b");
  AST_NONE_C: assert property (@(posedge core_clk) disable iff (!nrst)
    match[2] && act[2] == ACT_NONE |=> $stable(pin_out_ff[2]))
    else $error("none changed on c");
  AST_NONE_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    match[3] && act[3] == ACT_NONE |=> $stable(pin_out_ff[3]))
    else $error("none changed");
  AST_CMP_EVT: assert property (@(posedge core_clk) disable iff (!nrst)
    match != 4'h0 |=> compare_evt == $past(match))
    else $error("compare event lost");

  // Capture edges on every channel
  AST_RISE_CAP: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[0] && act[0] == EDGE_RISE && sync2_ff[0] && !sync3_ff[0]
    |=> gen_reg_ff[0] == $past(counter)) else $error("rise capture missed");
  AST_RISE_CAP_B: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[1] && act[1] == EDGE_RISE && rise[1]
    |=> gen_reg_ff[1] == $past(counter)) else $error("rise capture missed on b");
  AST_RISE_CAP_C: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[2] && act[2] == EDGE_RISE && rise[2]
    |=> gen_reg_ff[2] == $past(counter)) else $error("rise capture missed on c");
  AST_RISE_CAP_D: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[3] && act[3] == EDGE_RISE && rise[3]
    |=> gen_reg_ff[3] == $past(counter)) else $error("rise capture missed on d");
  AST_RISE_ONLY_A: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[0] && act[0] == EDGE_RISE && fall[0] |-> !cap_hit[0])
    else $error("rising mode took fall on a");
  AST_RISE_ONLY_B: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[1] && act[1] == EDGE_RISE && fall[1] |-> !cap_hit[1])
    else $error("rising mode took fall on b");
  AST_RISE_ONLY_C: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[2] && act[2] == EDGE_RISE && fall[2] |-> !cap_hit[2])
    else $error("rising mode took fall on c");
  AST_RISE_ONLY_D: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[3] && act[3] == EDGE_RISE && fall[3] |-> !cap_hit[3])
    else $error("rising mode took fall on d");
  AST_FALL_ONLY_A: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[0] && act[0] == EDGE_FALL && rise[0] |-> !cap_hit[0])
    else $error("falling mode took rise on a");
  AST_FALL_ONLY_B: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[1] && act[1] == EDGE_FALL && rise[1] |-> !cap_hit[1])
    else $error("falling mode took rise on b");
  AST_FALL_ONLY_C: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[2] && act[2] == EDGE_FALL && rise[2] |-> !cap_hit[2])
    else $error("falling mode took rise on c");
  AST_FALL_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[3] && act[3] == EDGE_FALL && rise[3] |-> !cap_hit[3])
    else $error("falling mode took rise");
  AST_BOTH_EDGE_A: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[0] && act[0][1] && (rise[0] || fall[0]) |=> capture_evt[0])
    else $error("both-edge capture missed on a");
  AST_BOTH_EDGE: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[1] && act[1][1] && (rise[1] || fall[1]) |=> capture_evt[1])
    else $error("both-edge capture missed");
  AST_BOTH_EDGE_C: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[2] && act[2][1] && (rise[2] || fall[2]) |=> capture_evt[2])
    else $error("both-edge capture missed on c");
  AST_BOTH_EDGE_D: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_cap[3] && act[3][1] && (rise[3] || fall[3]) |=> capture_evt[3])
    else $error("both-edge capture missed on d");
  AST_CAP_EVT: assert property (@(posedge core_clk) disable iff (!nrst)
    cap_hit != 4'h0 |=> capture_evt == $past(cap_hit))
    else $error("capture event lost");

  // Mode bit of channel d and the pin synchroniser
  AST_D_CAPTURE_MODE: assert property (@(posedge core_clk) disable iff (!nrst)
    pin_ctrl_cd_ff[MODE_HI_POS] |-> timer_pin_oe_n[3] && !match[3])
    else $error("capture mode still compares");
  AST_SYNC_DELAY: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(timer_pin_in[2]) ##1 timer_pin_in[2] |=> sync2_ff[2])
    else $error("sync delay wrong");

  COV_TOGGLE: cover property (@(posedge core_clk) disable iff (!nrst)
    match[0] && act[0] == ACT_TOGGLE);
  COV_CAP_D: cover property (@(posedge core_clk) disable iff (!nrst) cap_hit[3]);
  COV_BOTH: cover property (@(posedge core_clk) disable iff (!nrst)
    cap_hit[2] && fall[2] && act[2][1]);
  COV_HIGH_D: cover property (@(posedge core_clk) disable iff (!nrst)
    match[3] && act[3] == ACT_HIGH);
  COV_RD_CD: cover property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_PIN_CTRL_CD);

endmodule : tpc_pin_ctrl

// >>> core/tpc_pkg.sv
// Package with register map, field layout and encodings of the timer pin control block
package tpc_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_PIN_CTRL_AB = 3'h0;
  localparam logic [2:0] ADDR_PIN_CTRL_CD = 3'h1;
  localparam logic [2:0] ADDR_GENERAL_REG_A = 3'h2;
  localparam logic [2:0] ADDR_GENERAL_REG_B = 3'h3;
  localparam logic [2:0] ADDR_GENERAL_REG_C = 3'h4;
  localparam logic [2:0] ADDR_GENERAL_REG_D = 3'h5;
  // Field positions inside a pin control register (low nibble: first channel)
  localparam int ACT_LO_POS = 0;
  localparam int MODE_LO_POS = 2;
  localparam int ACT_HI_POS = 4;
  localparam int MODE_HI_POS = 6;
  localparam int RSVD_POS = 7;
  // Reset values and the forced-one mask of pin_ctrl_cd
  localparam logic [7:0] PIN_CTRL_AB_RST = 8'h00;
  localparam logic [7:0] PIN_CTRL_CD_RST = 8'h80;
  localparam logic [15:0] GENERAL_REG_RST = 16'hffff;
  localparam logic [7:0] PIN_CTRL_CD_RSVD = 8'h80;
  // Compare pin actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // Capture edge selections
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam int NUM_CHAN = 4;
endpackage : tpc_pkg

// >>> sim/timer_pin_io_control_tb_top.sv
// Self-checking bench of the timer pin control block
`timescale 1ns/10ps
module timer_pin_io_control_tb_top;
  import tpc_pkg::*;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, counter = 16'h0000, reg_rdata;
  logic [3:0] pin_out, pin_oe_n, capture_evt, compare_evt, pin_level, board_level = 4'h0;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  tpc_pin_ctrl tpc_pin_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .counter(counter), .timer_pin_in(pin_level), .timer_pin_out(pin_out),
    .timer_pin_oe_n(pin_oe_n), .capture_evt(capture_evt), .compare_evt(compare_evt));
  tpc_pin_board tpc_pin_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .board_level(board_level), .pin_level(pin_level));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Free-running count stands in for the timer counter; the tests last well under 1000 cycles
  always @(posedge core_clk) begin
    counter <= counter + 16'h0001;
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic t_regs();
    rd(ADDR_PIN_CTRL_AB, 16'h0000);
    rd(ADDR_PIN_CTRL_CD, 16'h0080);
    rd(ADDR_GENERAL_REG_D, 16'hffff);
    rd(3'h6, 16'h0000);
    wr(ADDR_PIN_CTRL_CD, 16'h0000);
    rd(ADDR_PIN_CTRL_CD, 16'h0080);
    wr(ADDR_PIN_CTRL_CD, 16'h00c0);
    rd(ADDR_PIN_CTRL_CD, 16'h00c0);
    chk(16'(pin_oe_n), 16'h0008);
    $display("test regs done");
  endtask : t_regs
  task automatic t_compare(input int ch);
    logic [1:0] acts [4] = '{ACT_HIGH, ACT_LOW, ACT_TOGGLE, ACT_NONE};
    logic exp_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [15:0] tgt;
    for (int i = 0; i < 4; i++) begin
      wr(3'(ch / 2), 16'(acts[i]) << (4 * (ch % 2)));
      tgt = counter + 16'h0010;
      wr(3'(ADDR_GENERAL_REG_A + ch), tgt);
      for (int k = 0; k < 40 && counter !== tgt; k++) @(negedge core_clk);
      chk(16'(pin_out[ch]), 16'(exp_pin[i]));
      @(negedge core_clk);
      chk(16'(compare_evt[ch]), 16'h0001);
    end
    $display("test compare %0d done", ch);
  endtask : t_compare
  task automatic t_capture(input int ch);
    int n;
    logic [15:0] exp_cap;
    for (int m = 0; m < 3; m++) begin
      wr(3'(ch / 2), 16'(4 + m) << (4 * (ch % 2)));
      for (int lv = 1; lv >= 0; lv--) begin
        n = 0;
        @(posedge core_clk);
        board_level[ch] <= lv[0];
        repeat (6) begin
          @(negedge core_clk);
          if (capture_evt[ch] === 1'b1) begin
            n++;
            // Stored value is the count of the cycle before the pulse
            exp_cap = counter - 16'h0001;
          end
        end
        chk(16'(n), 16'((lv == 1) ? (m != 1) : (m != 0)));
      end
      rd(3'(ADDR_GENERAL_REG_A + ch), exp_cap);
    end
    $display("test capture %0d done", ch);
  endtask : t_capture
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_compare(0);
    t_compare(1);
    t_compare(2);
    t_compare(3);
    t_capture(0);
    t_capture(1);
    t_capture(2);
    t_capture(3);
    final_report();
  end
endmodule : timer_pin_io_control_tb_top

// >>> sim/tpc_pin_board.sv
// Board-side model of the four timer pins
`timescale 1ns/10ps
module tpc_pin_board (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] board_level,
  output logic [3:0] pin_level
);
  // Board lets go of a pin while the timer drives it, so the wire carries the timer value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe_n[i] ? board_level[i] : pin_out[i];
    end
  end
endmodule : tpc_pin_board
